// ==== logic/prw_pkg.sv ====
// Package holding constants for the program runaway watchdog
package prw_pkg;
   localparam logic [31:0] PRW_CTRL_ADDR = 32'h0000_0000;
   localparam logic [31:0] PRW_STAT_ADDR = 32'h0000_0004;
   localparam logic [31:0] PRW_MASK_ADDR = 32'h0000_0008;
   localparam logic [3:0] PRW_KEY = 4'h5;
   localparam logic [3:0] PRW_KEY_READ = 4'hF;
   localparam int PRW_CS_BIT = 7;
   localparam int PRW_ARMED_BIT = 8;
   localparam int PRW_SEL_BIT = 9;
   localparam int PRW_CNT_BIT = 10;
   localparam int PRW_IRQ_OVF_BIT = 0;
   localparam int PRW_IRQ_CLR_BIT = 1;
   localparam int PRW_IRQ_W = 2;
   localparam int PRW_RST_INSN_CYCLES = 4;
   localparam int PRW_CLK_PER_INSN_DEF = 4;
   localparam logic [1:0] PRW_RESP_OKAY = 2'h0;
   localparam logic [1:0] PRW_RESP_SLVERR = 2'h2;
endpackage

// ==== logic/prw_core.sv ====
// One-bit watchdog counter with overflow and clear handling
`timescale 1ns/1ps
module prw_core (
   // Clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // Control
   input wire logic armed_i,
   input wire logic tap_i,
   input wire logic clr_i,
   // State
   output logic cnt_o,
   output logic ovf_o
);
   logic tap_q;
   logic next_tap_q;
   logic next_cnt;
   logic next_ovf;
   logic tap_rise;

   always_comb begin
      next_tap_q = tap_i;
      tap_rise = tap_i & ~tap_q;
      next_cnt = cnt_o;
      next_ovf = 1'b0;
      if (!armed_i || clr_i) begin
         next_cnt = 1'b0;
      end else if (tap_rise) begin
         if (cnt_o) begin
            next_cnt = 1'b0;
            next_ovf = 1'b1;
         end else begin
            next_cnt = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tap_q <= 1'b0;
         cnt_o <= 1'b0;
         ovf_o <= 1'b0;
      end else begin
         tap_q <= next_tap_q;
         cnt_o <= next_cnt;
         ovf_o <= next_ovf;
      end
   end
endmodule

// ==== logic/prw_top.sv ====
// Watchdog top: AXI4-Lite registers, source select, CPU reset pulse, interrupt
//
// Chosen here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module prw_top import prw_pkg::*; #(
   parameter int CLK_PER_INSN = PRW_CLK_PER_INSN_DEF
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   // Source counters
   input wire logic TB_TAP_I,
   input wire logic TB_CLR_I,
   input wire logic PS_TAP_I,
   input wire logic PS_CLR_I,
   input wire logic LOW_POWER_I,
   // CPU reset and interrupt
   output logic CPU_RST_O,
   output logic IRQ_O,
   // AXI4-Lite write
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] AWADDR_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   output logic BVALID_O,
   input wire logic BREADY_I,
   output logic [1:0] BRESP_O,
   // AXI4-Lite read
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   input wire logic [31:0] ARADDR_I,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O
);
   localparam int RST_LEN = PRW_RST_INSN_CYCLES * CLK_PER_INSN;
   localparam int RW = $clog2(RST_LEN + 1);

   // Refused at elaboration: a pulse of zero cycles would never reach the CPU
   if (CLK_PER_INSN < 1) begin : g_bad_param
      $error("CLK_PER_INSN must be at least 1");
   end

   logic aw_held, w_held, armed, cs;
   logic [31:0] aw_addr, w_data;
   logic [3:0] w_strb;
   logic [PRW_IRQ_W-1:0] stat, mask;
   logic [RW-1:0] rst_cnt;
   logic next_aw_held, next_w_held, next_armed, next_cs;
   logic [31:0] next_aw_addr, next_w_data, next_rdata;
   logic [3:0] next_w_strb;
   logic [PRW_IRQ_W-1:0] next_stat, next_mask;
   logic [RW-1:0] next_rst_cnt;
   logic next_bvalid, next_rvalid, next_cpu_rst, next_irq;
   logic [1:0] next_bresp, next_rresp;
   logic wr_fire, rd_fire, key_wr, sw_clr, sel_tap, src_clr, wd_clr;
   logic wd_cnt, wd_ovf;

   // Clear and tap come from the same selected counter
   assign sel_tap = cs ? PS_TAP_I : TB_TAP_I;
   assign src_clr = cs ? PS_CLR_I : TB_CLR_I;
   assign wd_clr = sw_clr | src_clr | LOW_POWER_I;

   prw_core u_core (
      .clk_i(CLK_I),
      .arst_n_i(ARST_N_I),
      .armed_i(armed),
      .tap_i(sel_tap),
      .clr_i(wd_clr),
      .cnt_o(wd_cnt),
      .ovf_o(wd_ovf)
   );

   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = BVALID_O;
      next_bresp = BRESP_O;
      next_rvalid = RVALID_O;
      next_rresp = RRESP_O;
      next_rdata = RDATA_O;
      next_armed = armed;
      next_cs = cs;
      next_mask = mask;
      next_stat = stat;
      key_wr = 1'b0;
      sw_clr = 1'b0;
      if (AWVALID_I && AWREADY_O) begin
         next_aw_held = 1'b1;
         next_aw_addr = AWADDR_I;
      end
      if (WVALID_I && WREADY_O) begin
         next_w_held = 1'b1;
         next_w_data = WDATA_I;
         next_w_strb = WSTRB_I;
      end
      wr_fire = aw_held && w_held && !BVALID_O;
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = PRW_RESP_OKAY;
         if (aw_addr == PRW_CTRL_ADDR) begin
            // Only bits 7 and 3:0 matter; bits 6:4 are dropped
            key_wr = w_strb[0] && (w_data[3:0] == PRW_KEY);
            if (key_wr) begin
               next_cs = armed ? cs : w_data[PRW_CS_BIT];
               next_armed = 1'b1;
               sw_clr = armed;
            end
         end else if (aw_addr == PRW_MASK_ADDR) begin
            if (w_strb[0]) begin
               next_mask = w_data[PRW_IRQ_W-1:0];
            end
         end else if (aw_addr != PRW_STAT_ADDR) begin
            next_bresp = PRW_RESP_SLVERR;
         end
      end
      if (BVALID_O && BREADY_I) begin
         next_bvalid = 1'b0;
      end
      rd_fire = ARVALID_I && ARREADY_O;
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rresp = PRW_RESP_OKAY;
         next_rdata = 32'h0000_0000;
         unique case (ARADDR_I)
            PRW_CTRL_ADDR: begin
               next_rdata[3:0] = PRW_KEY_READ;
               next_rdata[PRW_CS_BIT] = cs;
               next_rdata[PRW_ARMED_BIT] = armed;
               next_rdata[PRW_SEL_BIT] = sel_tap;
               next_rdata[PRW_CNT_BIT] = wd_cnt;
            end
            PRW_STAT_ADDR: begin
               next_rdata[PRW_IRQ_W-1:0] = stat;
               next_stat = '0;
            end
            PRW_MASK_ADDR: next_rdata[PRW_IRQ_W-1:0] = mask;
            default: next_rresp = PRW_RESP_SLVERR;
         endcase
      end
      if (RVALID_O && RREADY_I) begin
         next_rvalid = 1'b0;
      end
      // Events set after the read clear so none is lost
      if (wd_ovf) begin
         next_stat[PRW_IRQ_OVF_BIT] = 1'b1;
      end
      if (wd_clr && armed) begin
         next_stat[PRW_IRQ_CLR_BIT] = 1'b1;
      end
      next_irq = |(next_stat & next_mask);
   end

   // Reset pulse stretcher, restarted by any new overflow
   always_comb begin
      next_rst_cnt = rst_cnt;
      if (wd_ovf) begin
         next_rst_cnt = RW'(RST_LEN);
      end else if (rst_cnt != '0) begin
         next_rst_cnt = rst_cnt - RW'(1);
      end
      next_cpu_rst = (next_rst_cnt != '0);
   end

   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         aw_held <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_held <= 1'b0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         BVALID_O <= 1'b0;
         BRESP_O <= 2'h0;
         RVALID_O <= 1'b0;
         RRESP_O <= 2'h0;
         RDATA_O <= 32'h0000_0000;
         AWREADY_O <= 1'b0;
         WREADY_O <= 1'b0;
         ARREADY_O <= 1'b0;
         armed <= 1'b0;
         cs <= 1'b0;
         stat <= '0;
         mask <= '0;
         IRQ_O <= 1'b0;
         rst_cnt <= '0;
         CPU_RST_O <= 1'b0;
      end else begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         BVALID_O <= next_bvalid;
         BRESP_O <= next_bresp;
         RVALID_O <= next_rvalid;
         RRESP_O <= next_rresp;
         RDATA_O <= next_rdata;
         // Ready only while the holding slot will be empty next cycle
         AWREADY_O <= !next_aw_held;
         WREADY_O <= !next_w_held;
         ARREADY_O <= !next_rvalid && !(ARVALID_I && ARREADY_O);
         armed <= next_armed;
         cs <= next_cs;
         stat <= next_stat;
         mask <= next_mask;
         IRQ_O <= next_irq;
         rst_cnt <= next_rst_cnt;
         CPU_RST_O <= next_cpu_rst;
      end
   end
endmodule

// ==== testbench/prw_top_properties.sv ====
// Checker bound to the watchdog top: bus handshakes and reset pulse
`timescale 1ns/1ps
module prw_chk import prw_pkg::*; #(
   parameter int CLK_PER_INSN = PRW_CLK_PER_INSN_DEF
) (
   // Watched ports
   input wire logic CLK_I,
   input wire logic ARST_N_I,
   input wire logic CPU_RST_O,
   input wire logic AWVALID_I,
   input wire logic AWREADY_O,
   input wire logic WVALID_I,
   input wire logic WREADY_O,
   input wire logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic [31:0] ARADDR_I,
   input wire logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic [31:0] RDATA_O,
   input wire logic [1:0] RRESP_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!ARST_N_I);
   // Cycles the CPU reset has been high, and the address of the pending read
   int rc;
   logic [31:0] la;
   always_ff @(posedge CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         rc <= 0;
         la <= '0;
      end else begin
         rc <= CPU_RST_O ? rc + 1 : 0;
         if (ARVALID_I && ARREADY_O) begin
            la <= ARADDR_I;
         end
      end
   end
   a_rst_len: assert property ($fell(CPU_RST_O) |-> rc == 4 * CLK_PER_INSN)
      else $error("cpu reset pulse length wrong");
   a_rst_max: assert property (CPU_RST_O |-> rc < 4 * CLK_PER_INSN)
      else $error("cpu reset pulse too long");
   a_ctrl_key: assert property (RVALID_O && la == PRW_CTRL_ADDR |-> RDATA_O[3:0] == PRW_KEY_READ)
      else $error("control field did not read all ones");
   a_unmapped_err: assert property (RVALID_O && la > PRW_MASK_ADDR |-> RRESP_O == PRW_RESP_SLVERR)
      else $error("unmapped read not refused");
   a_r_answer: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
      else $error("read answer late");
   a_r_stand: assert property (RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
      else $error("read data dropped");
   a_ar_refuse: assert property (RVALID_O |-> !ARREADY_O)
      else $error("read address taken while answering");
   a_aw_refuse: assert property (AWVALID_I && AWREADY_O |=> !AWREADY_O)
      else $error("write address taken twice");
   a_b_answer: assert property (AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:3] BVALID_O)
      else $error("write response late");
   a_b_stand: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
      else $error("write response dropped");
   cover property ($rose(CPU_RST_O));
   cover property (RVALID_O && RRESP_O == PRW_RESP_SLVERR);
   cover property (BVALID_O && BREADY_I);
endmodule

bind prw_top prw_chk #(.CLK_PER_INSN(CLK_PER_INSN)) u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
   .CPU_RST_O(CPU_RST_O), .AWVALID_I(AWVALID_I), .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I),
   .WREADY_O(WREADY_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
   .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
   .RDATA_O(RDATA_O), .RRESP_O(RRESP_O));

// ==== testbench/prw_src.sv ====
// Behavioural timebase and prescaler source counters
`timescale 1ns/1ps
module prw_src (
   // Clock, reset, requests
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic tb_req_i,
   input wire logic ps_req_i,
   input wire logic lp_i,
   // Taps and clears
   output logic tb_tap_o,
   output logic ps_tap_o,
   output logic tb_clr_o,
   output logic ps_clr_o
);
   // Short counters stand in for the long taps so the run stays brief
   logic [6:0] tc;
   logic [7:0] pc;
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tc <= '0;
         pc <= '0;
         tb_clr_o <= 1'b0;
         ps_clr_o <= 1'b0;
      end else begin
         // Timebase stops and clears in low power, as its oscillator does
         tc <= (tb_req_i || lp_i) ? 7'h00 : tc + 7'h01;
         pc <= ps_req_i ? 8'h00 : pc + 8'h01;
         tb_clr_o <= tb_req_i;
         ps_clr_o <= ps_req_i;
      end
   end
   assign tb_tap_o = tc[6];
   assign ps_tap_o = pc[7];
endmodule

// ==== testbench/tb_program_runaway_watchdog.sv ====
// Testbench for the watchdog top
`timescale 1ns/1ps
module tb_program_runaway_watchdog;
   import prw_pkg::*;
   logic clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, timebase_clear_bit = 0, psr = 0, lp = 0;
   logic brdy = 0, rrdy = 0;
   logic [31:0] ad = '0, wd = '0, ra = '0, d;
   wire logic tt, pt, tc, pc, cr, irq, awr, wr_r, bv, arr, rv;
   wire logic [1:0] br, rr;
   wire logic [31:0] rd_d;
   int bad_count = 0, n_checks = 0, nrst = 0, tn = 0, seed = 36, t;
   always #2 clk = ~clk;
   always @(posedge cr) nrst++;
   prw_src u_prw_src (.clk_i(clk), .arst_n_i(rst_n), .tb_req_i(timebase_clear_bit), .ps_req_i(psr), .lp_i(lp),
      .tb_tap_o(tt), .ps_tap_o(pt), .tb_clr_o(tc), .ps_clr_o(pc));
   prw_top u_prw_top (.CLK_I(clk), .ARST_N_I(rst_n), .TB_TAP_I(tt), .TB_CLR_I(tc), .PS_TAP_I(pt),
      .PS_CLR_I(pc), .LOW_POWER_I(lp), .CPU_RST_O(cr), .IRQ_O(irq), .AWVALID_I(awv),
      .AWREADY_O(awr), .AWADDR_I(ad), .WVALID_I(wv), .WREADY_O(wr_r), .WDATA_I(wd),
      .WSTRB_I(4'hF), .BVALID_O(bv), .BREADY_I(brdy), .BRESP_O(br), .ARVALID_I(arv),
      .ARREADY_O(arr), .ARADDR_I(ra), .RVALID_O(rv), .RREADY_I(rrdy), .RDATA_O(rd_d), .RRESP_O(rr));
   task automatic chk(input logic [31:0] g, e);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] a, v, input logic [1:0] er = PRW_RESP_OKAY);
      awv <= 1;
      wv <= 1;
      ad <= a;
      wd <= v;
      fork
         begin do @(posedge clk); while (awr !== 1); awv <= 0; end
         begin do @(posedge clk); while (wr_r !== 1); wv <= 0; end
      join
      // A late ready keeps the response standing for a few cycles
      cyc({$random(seed)} % 3);
      brdy <= 1;
      do @(posedge clk); while (bv !== 1);
      brdy <= 0;
      chk(br, er);
   endtask
   task automatic rd(input logic [31:0] a, m, e, input logic [1:0] er);
      arv <= 1;
      ra <= a;
      do @(posedge clk); while (arr !== 1);
      arv <= 0;
      cyc({$random(seed)} % 3);
      rrdy <= 1;
      do @(posedge clk); while (rv !== 1);
      rrdy <= 0;
      chk(rd_d & m, e);
      chk(rr, er);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic pulse(input int n, gap, logic ps);
      repeat (n) begin
         cyc(gap);
         if (ps) psr <= 1; else timebase_clear_bit <= 1;
         @(posedge clk);
         psr <= 0;
         timebase_clear_bit <= 0;
      end
   endtask
   // CPU reset must not come before one tap period less 4 cycles after a clear; the wait ends, passing, after two periods plus 8
   task automatic ovf(input int p);
      t = 0;
      while (cr !== 1 && t < 2 * p + 8) begin @(posedge clk); t++; end
      chk(t >= p - 4 && t <= 2 * p + 8, 1);
   endtask
   task automatic note();
      $display("test %0d done", tn++);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      cyc(30000);
      bad_count++;
      summarize();
   end
   initial begin
      cyc(16);
      rst_n <= 1;
      cyc(2);
      rd(PRW_CTRL_ADDR, 32'h17F, 32'h00F, PRW_RESP_OKAY);
      rd(32'h0000_000C, 32'hFFFF_FFFF, 32'h0000_0000, PRW_RESP_SLVERR);
      wr(32'h0000_000C, 32'h0000_0005, PRW_RESP_SLVERR);
      repeat (4) begin
         d = $random(seed);
         d[3:0] = (d[3:0] == PRW_KEY) ? 4'hA : d[3:0];
         wr(PRW_CTRL_ADDR, d);
      end
      cyc(600);
      chk(nrst, 0);
      rd(PRW_CTRL_ADDR, 32'h180, 0, PRW_RESP_OKAY);
      wr(PRW_MASK_ADDR, 1);
      wr(PRW_CTRL_ADDR, 32'h85);
      rd(PRW_CTRL_ADDR, 32'h180, 32'h180, PRW_RESP_OKAY);
      note();
      pulse(8, 200, 1);
      chk(nrst, 0);
      pulse(6, 100, 0);
      chk(nrst, 1);
      chk(irq, 1);
      rd(PRW_STAT_ADDR, 1, 1, PRW_RESP_OKAY);
      cyc(3);
      chk(irq, 0);
      note();
      wr(PRW_CTRL_ADDR, 32'h85);
      ovf(256);
      wr(PRW_CTRL_ADDR, 32'h05);
      rd(PRW_CTRL_ADDR, 32'h180, 32'h180, PRW_RESP_OKAY);
      lp <= 1;
      cyc(1200);
      chk(nrst, 2);
      lp <= 0;
      repeat (10) begin
         cyc({$random(seed)} % 150 + 20);
         wr(PRW_CTRL_ADDR, 32'h85);
      end
      chk(nrst, 2);
      note();
      rst_n <= 0;
      cyc(2);
      rst_n <= 1;
      cyc(2);
      rd(PRW_CTRL_ADDR, 32'h180, 0, PRW_RESP_OKAY);
      wr(PRW_CTRL_ADDR, 32'h05);
      pulse(6, 100, 0);
      chk(nrst, 2);
      ovf(128);
      note();
      summarize();
   end
endmodule
